// >>> verilog/regsel_params.svh
// offsets, field positions, reset values and timing counts of the register select block
`ifndef REGSEL_PARAMS_SVH
`define REGSEL_PARAMS_SVH

// ----------------------------------------------------------------------------
// wishbone byte offsets
// ----------------------------------------------------------------------------
`define WB_CFG_ADDR 8'h00
`define WB_STATUS_ADDR 8'h04
`define WB_TABLE_BIT 7

// ----------------------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------------------
`define CFG_BASE_LSB 0
`define CFG_BASE_MSB 7
`define CFG_COUNT_LSB 8
`define CFG_COUNT_MSB 11
`define CFG_WIDE_BIT 12
`define CFG_BASE_RESET 8'h00
`define CFG_COUNT_RESET 4'h0
`define CFG_WIDE_RESET 1'b0

// ----------------------------------------------------------------------------
// host address fields
// ----------------------------------------------------------------------------
`define ADDR_PAGE_MSB 17
`define ADDR_PAGE_LSB 13
`define ADDR_BASE_MSB 12
`define ADDR_BASE_LSB 5
`define ADDR_INDEX_MSB 4
`define ADDR_INDEX_LSB 1

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define STROBE_DELAY_NS 85
`define STROBE_DELAY_CYC ((`STROBE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> verilog/regsel_pkg.sv
// types shared by the register select block
package regsel_pkg;

    // host bus pins, all active low as carried on the bus
    typedef struct packed {
        logic [17:0] addr_n;
        logic c1_n;
        logic c0_n;
        logic msyn_n;
    } host_bus_t;

    // one cell of the select table
    typedef struct packed {
        logic upper_select_bit_high;
        logic upper_select_bit_low;
        logic local_register_flag;
        logic [4:0] register_select_code;
    } lut_entry_t;

    // strobe sequencer, gray along idle-delay-strobe-hold
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_DELAY = 2'h1,
        SEQ_STROBE = 2'h3,
        SEQ_HOLD = 2'h2
    } seq_state_t;

endpackage

// >>> verilog/host_register_select_decode.sv
// host port register selection: address decode, select table and strobe decoders
// Operation
// [RULE_01] select only within the io page
// [RULE_02] base bits compared, any mismatch blocks select; in wide mode the code skips base bit 0 (address bit 5)
// [RULE_03] base setting zero intact, one removed
// [RULE_04] invert active-low address before comparing
// [RULE_05] address bits 4..1 index table, top zero
// [RULE_06] wide mode feeds bit 5 into index
// [RULE_07] compare index top bits with register count
// [RULE_08] out of range gives no reply
// [RULE_09] master holds address 150 ns before sync
// [RULE_10] select needs sync plus match, starts strobes
// [RULE_11] local entries inhibit drive handshake
// [RULE_12] remote entries raise drive request
// [RULE_13] shared first command register decodes remote
// [RULE_14] five select bits go to drive
// [RULE_15] low select bits feed lower decoder
// [RULE_16] direction line picks write or read outputs
// [RULE_17] lower decoder needs local and select
// [RULE_18] low select bits serve both roles
// [RULE_19] upper bits drive upper decoder, same direction
// [RULE_20] upper decoder enabled by select alone
// [RULE_21] control lines encode cycle, bit 0 byte
// [RULE_22] local strobe 85 ns after sync
// [RULE_23] decode is combinational, settled before strobe
`include "regsel_params.svh"

module host_register_select_decode (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire regsel_pkg::host_bus_t host_pins,
    output logic device_selected,
    output logic local_register_flag,
    output logic [4:0] register_select_code,
    output logic [7:0] lower_decode,
    output logic [7:0] upper_decode,
    output logic local_register_strobe,
    output logic drive_request,
    output logic reply_permitted,
    output logic register_in_range,
    output logic drive_write_direction,
    output logic odd_byte_write
);
    import regsel_pkg::*;

    localparam logic [3:0] STROBE_LAST = 4'(`STROBE_DELAY_CYC - 2);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    // bcd to decimal decoder; when disabled, all eight outputs stay low
    function automatic logic [7:0] decode_ten(input logic en, input logic d2,
                                              input logic [1:0] d10);
        logic [7:0] hot;
        hot = 8'h00;
        if (en)
        begin
            hot[{d2, d10}] = 1'b1;
        end
        return hot;
    endfunction

    // power-up contents of the select table
    function automatic lut_entry_t default_entry(input logic [4:0] idx);
        lut_entry_t e;
        e = '{1'b1, 1'b1, 1'b0, idx};
        case (idx)
            5'h00: e = '{1'b1, 1'b0, 1'b0, idx}; // RULE_13
            5'h01: e = '{1'b0, 1'b0, 1'b1, 5'h03};
            5'h02: e = '{1'b1, 1'b1, 1'b1, 5'h02};
            5'h03: e = '{1'b1, 1'b1, 1'b1, 5'h01};
            5'h04: e = '{1'b1, 1'b1, 1'b1, 5'h00};
            5'h05: e = '{1'b0, 1'b1, 1'b0, idx};
            default: e = '{1'b1, 1'b1, 1'b0, idx};
        endcase
        return e;
    endfunction

    // ------------------------------------------------------------------------
    // host pin synchronisers
    // ------------------------------------------------------------------------
    host_bus_t host_meta_q;
    host_bus_t host_sync_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            host_meta_q <= '1;
            host_sync_q <= '1;
        end
        else
        begin
            host_meta_q <= host_pins;
            host_sync_q <= host_meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // configuration and select table
    // ------------------------------------------------------------------------
    logic [7:0] cfg_base_q;
    logic [3:0] cfg_count_q;
    logic cfg_wide_q;
    lut_entry_t lut_q [32];
    logic wb_ack_q;
    logic [31:0] wb_dat_q;

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
    wire wb_wr = wb_req && wb_we_i;
    wire hit_cfg = wb_adr_i == `WB_CFG_ADDR;
    wire hit_status = wb_adr_i == `WB_STATUS_ADDR;
    wire hit_table = wb_adr_i[`WB_TABLE_BIT];
    wire [4:0] wb_index = wb_adr_i[6:2];

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cfg_base_q <= `CFG_BASE_RESET; // RULE_03
            cfg_count_q <= `CFG_COUNT_RESET;
            cfg_wide_q <= `CFG_WIDE_RESET;
        end
        else if (wb_wr && hit_cfg)
        begin
            if (wb_sel_i[0])
            begin
                cfg_base_q <= wb_dat_i[`CFG_BASE_MSB:`CFG_BASE_LSB]; // RULE_03
            end
            if (wb_sel_i[1])
            begin
                cfg_count_q <= wb_dat_i[`CFG_COUNT_MSB:`CFG_COUNT_LSB];
                cfg_wide_q <= wb_dat_i[`CFG_WIDE_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 32; i++)
            begin
                lut_q[i] <= default_entry(5'(i));
            end
        end
        else if (wb_wr && hit_table && wb_sel_i[0])
        begin
            lut_q[wb_index] <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // address decode, all combinational
    // ------------------------------------------------------------------------
    wire [17:0] addr = ~host_sync_q.addr_n; // RULE_04
    wire msyn = !host_sync_q.msyn_n;
    wire write_dir = !host_sync_q.c1_n; // RULE_21
    wire io_page = &addr[`ADDR_PAGE_MSB:`ADDR_PAGE_LSB]; // RULE_01
    wire [7:0] base_mask = {7'h7F, !cfg_wide_q}; // RULE_06
    wire [7:0] base_diff = (addr[`ADDR_BASE_MSB:`ADDR_BASE_LSB] ^ cfg_base_q) & base_mask;
    wire base_match = base_diff == 8'h00; // RULE_02
    wire [4:0] lut_index = {cfg_wide_q & addr[5], addr[4:1]}; // RULE_05 RULE_06
    wire [3:0] range_index = cfg_wide_q ? addr[5:2] : addr[4:1]; // RULE_07
    wire in_range = range_index < cfg_count_q; // RULE_07
    wire sel_now = msyn && io_page && base_match; // RULE_10
    lut_entry_t entry;
    assign entry = lut_q[lut_index]; // RULE_23
    wire [1:0] upper_code = {entry.upper_select_bit_high, entry.upper_select_bit_low};
    wire lower_en = sel_now && entry.local_register_flag; // RULE_17
    // C1 asserted drives D2 low: write strobes on 0..3, read enables above
    wire [7:0] lower_d = decode_ten(lower_en, !write_dir,
                                    entry.register_select_code[1:0]); // RULE_15 RULE_16 RULE_18
    wire [7:0] upper_d = decode_ten(sel_now, !write_dir, upper_code); // RULE_19 RULE_20
    wire request_d = sel_now && !entry.local_register_flag && in_range; // RULE_11 RULE_12
    wire odd_d = sel_now && write_dir && !host_sync_q.c0_n && addr[0]; // RULE_21

    // ------------------------------------------------------------------------
    // registered host-side outputs
    // ------------------------------------------------------------------------
    logic device_selected_q;
    logic local_flag_q;
    logic [4:0] select_code_q;
    logic [7:0] lower_q;
    logic [7:0] upper_q;
    logic request_q;
    logic reply_q;
    logic in_range_q;
    logic write_dir_q;
    logic odd_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            device_selected_q <= 1'b0;
            local_flag_q <= 1'b0;
            select_code_q <= 5'h00;
            lower_q <= 8'h00;
            upper_q <= 8'h00;
            request_q <= 1'b0;
            reply_q <= 1'b0;
            in_range_q <= 1'b0;
            write_dir_q <= 1'b0;
            odd_q <= 1'b0;
        end
        else
        begin
            device_selected_q <= sel_now; // RULE_10
            local_flag_q <= sel_now && entry.local_register_flag; // RULE_11
            select_code_q <= entry.register_select_code; // RULE_14
            lower_q <= lower_d;
            upper_q <= upper_d;
            request_q <= request_d; // RULE_12
            reply_q <= sel_now && in_range; // RULE_08
            in_range_q <= in_range;
            write_dir_q <= write_dir;
            odd_q <= odd_d;
        end
    end

    // ------------------------------------------------------------------------
    // local register strobe sequencer
    // ------------------------------------------------------------------------
    seq_state_t state_q;
    seq_state_t state_d;
    logic [3:0] count_q;
    logic strobe_q;

    wire delay_done = state_q == SEQ_DELAY && count_q == STROBE_LAST;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SEQ_IDLE: state_d = device_selected_q ? SEQ_DELAY : SEQ_IDLE; // RULE_10
            SEQ_DELAY:
            begin
                if (!device_selected_q)
                begin
                    state_d = SEQ_IDLE;
                end
                else if (delay_done)
                begin
                    state_d = SEQ_STROBE;
                end
            end
            SEQ_STROBE: state_d = SEQ_HOLD;
            SEQ_HOLD: state_d = device_selected_q ? SEQ_HOLD : SEQ_IDLE;
            default: state_d = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_q <= SEQ_IDLE;
            count_q <= 4'h0;
            strobe_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= (state_q == SEQ_DELAY) ? count_q + 4'h1 : 4'h0;
            strobe_q <= delay_done && device_selected_q && local_flag_q
                        && in_range_q; // RULE_22
        end
    end

    // ------------------------------------------------------------------------
    // wishbone answer
    // ------------------------------------------------------------------------
    wire [31:0] cfg_rd = {19'h00000, cfg_wide_q, cfg_count_q, cfg_base_q};
    wire [31:0] status_rd = {24'h000000, in_range_q, select_code_q,
                             local_flag_q, device_selected_q};
    wire [31:0] table_rd = {24'h000000, lut_q[wb_index]};
    wire [31:0] rd_d = hit_cfg ? cfg_rd : hit_status ? status_rd
                     : hit_table ? table_rd : 32'h00000000;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end
        else
        begin
            wb_ack_q <= wb_req;
            wb_dat_q <= wb_req ? rd_d : 32'h00000000;
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;
    assign device_selected = device_selected_q;
    assign local_register_flag = local_flag_q;
    assign register_select_code = select_code_q;
    assign lower_decode = lower_q;
    assign upper_decode = upper_q;
    assign local_register_strobe = strobe_q;
    assign drive_request = request_q;
    assign reply_permitted = reply_q;
    assign register_in_range = in_range_q;
    assign drive_write_direction = write_dir_q;
    assign odd_byte_write = odd_q;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    property p_io_page;
        @(posedge clk_sys) disable iff (rst)
        device_selected_q |-> $past(io_page);
    endproperty
    a_io_page: assert property (p_io_page) else $error("select outside io page"); // RULE_01

    property p_base_match;
        @(posedge clk_sys) disable iff (rst)
        device_selected_q |-> $past(base_diff) == 8'h00;
    endproperty
    a_base_match: assert property (p_base_match) else $error("select on base mismatch"); // RULE_02

    property p_narrow_index;
        @(posedge clk_sys) disable iff (rst)
        (sel_now && !cfg_wide_q) |=> select_code_q
            == $past(lut_q[{1'b0, addr[4:1]}].register_select_code);
    endproperty
    a_narrow_index: assert property (p_narrow_index) else $error("narrow index wrong"); // RULE_05

    property p_wide_index;
        @(posedge clk_sys) disable iff (rst)
        (sel_now && cfg_wide_q) |=> select_code_q
            == $past(lut_q[addr[5:1]].register_select_code);
    endproperty
    a_wide_index: assert property (p_wide_index) else $error("wide index wrong"); // RULE_06

    property p_no_reply_out_of_range;
        @(posedge clk_sys) disable iff (rst)
        (sel_now && !in_range) |=> !reply_permitted && !drive_request && device_selected;
    endproperty
    a_no_reply_out_of_range: assert property (p_no_reply_out_of_range) // RULE_08
        else $error("reply outside register count");

    property p_local_inhibits;
        @(posedge clk_sys) disable iff (rst)
        local_register_flag |-> !drive_request;
    endproperty
    a_local_inhibits: assert property (p_local_inhibits) else $error("local raised request"); // RULE_11

    property p_remote_requests;
        @(posedge clk_sys) disable iff (rst)
        (sel_now && !entry.local_register_flag && in_range) |=> drive_request;
    endproperty
    a_remote_requests: assert property (p_remote_requests) else $error("remote no request"); // RULE_12

    property p_lower_enable;
        @(posedge clk_sys) disable iff (rst)
        (lower_decode != 8'h00) |-> device_selected && local_register_flag
            && $onehot(lower_decode);
    endproperty
    a_lower_enable: assert property (p_lower_enable) else $error("lower decoder enable"); // RULE_17

    property p_direction;
        @(posedge clk_sys) disable iff (rst)
        (lower_decode[7:4] != 4'h0 || upper_decode[7:4] != 4'h0) |-> !drive_write_direction;
    endproperty
    a_direction: assert property (p_direction) else $error("read output on write"); // RULE_16

    property p_upper_enable;
        @(posedge clk_sys) disable iff (rst)
        device_selected == (upper_decode != 8'h00);
    endproperty
    a_upper_enable: assert property (p_upper_enable) else $error("upper decoder enable"); // RULE_20

    property p_strobe_delay;
        @(posedge clk_sys) disable iff (rst)
        ($rose(device_selected) && local_register_flag && register_in_range)
            ##1 device_selected[*8] |=> local_register_strobe ##1 !local_register_strobe;
    endproperty
    a_strobe_delay: assert property (p_strobe_delay) else $error("strobe timing"); // RULE_22

    property p_strobe_local_only;
        @(posedge clk_sys) disable iff (rst)
        local_register_strobe |-> $past(local_register_flag) && !drive_request;
    endproperty
    a_strobe_local_only: assert property (p_strobe_local_only) else $error("strobe on remote"); // RULE_11

    c_local_strobe: cover property (@(posedge clk_sys) disable iff (rst)
        local_register_strobe);
    c_drive_request: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(drive_request));
    c_wide_select: cover property (@(posedge clk_sys) disable iff (rst)
        sel_now && cfg_wide_q && addr[5]);
    c_out_of_range: cover property (@(posedge clk_sys) disable iff (rst)
        sel_now && !in_range);

endmodule

// >>> test/host_master_model.sv
// host bus master model driving the active-low host pins
module host_master_model (
    input wire logic clk_sys,
    output regsel_pkg::host_bus_t host_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import regsel_pkg::*;

    // ------------------------------------------------------------------------
    // idle bus
    // ------------------------------------------------------------------------
    // released lines float to the pull-up level, i.e. deasserted
    initial host_pins = '1;

    // ------------------------------------------------------------------------
    // bus cycle phases
    // ------------------------------------------------------------------------
    // address and control settle for 15 cycles before sync falls
    task automatic start_cycle(input logic [17:0] addr, input logic [1:0] ctl);
        @(posedge clk_sys);
        host_pins.addr_n <= ~addr;
        host_pins.c1_n <= ~ctl[1];
        host_pins.c0_n <= ~ctl[0];
        repeat (15) @(posedge clk_sys);
        host_pins.msyn_n <= 1'b0;
    endtask

    // sync rises first, address is dropped a cycle later, then idle gap
    task automatic end_cycle();
        @(posedge clk_sys);
        host_pins.msyn_n <= 1'b1;
        @(posedge clk_sys);
        host_pins <= '1;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule

// >>> test/tb_host_register_select_decode.sv
// self-checking bench of the host register select decode block
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("unexpected %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module tb_host_register_select_decode;
    timeunit 1ns;
    timeprecision 1ps;
    import regsel_pkg::*;

    // ------------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    host_bus_t host_pins;
    logic device_selected, local_register_flag, local_register_strobe;
    logic [4:0] register_select_code;
    logic [7:0] lower_decode, upper_decode;
    logic drive_request, reply_permitted, register_in_range;
    logic drive_write_direction, odd_byte_write;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000B5E1;
    logic [7:0] tbl [32];
    logic [7:0] base;
    logic [3:0] count;
    logic wide;

    always #5 clk_sys = ~clk_sys;

    host_register_select_decode i_host_register_select_decode (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .host_pins(host_pins), .device_selected(device_selected),
        .local_register_flag(local_register_flag),
        .register_select_code(register_select_code), .lower_decode(lower_decode),
        .upper_decode(upper_decode), .local_register_strobe(local_register_strobe),
        .drive_request(drive_request), .reply_permitted(reply_permitted),
        .register_in_range(register_in_range),
        .drive_write_direction(drive_write_direction), .odd_byte_write(odd_byte_write)
    );

    host_master_model i_host_master_model (
        .clk_sys(clk_sys),
        .host_pins(host_pins)
    );

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic close_out();
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            close_out();
        end
    end

    // classic single wishbone cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] rd);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // one host cycle checked against the behavioural model
    task automatic host_check(input logic [17:0] a, input logic [1:0] ctl);
        logic [4:0] idx;
        logic [7:0] e, lo, up;
        logic sel, loc, rng, c1;
        idx = wide ? a[5:1] : {1'b0, a[4:1]};
        e = tbl[idx];
        sel = (&a[17:13]) && (wide ? a[12:6] == base[7:1] : a[12:5] == base);
        loc = e[5];
        rng = wide ? a[5:2] < count : a[4:1] < count;
        c1 = ctl[1];
        lo = (sel & loc) ? 8'h01 << {~c1, e[1:0]} : 8'h00;
        up = sel ? 8'h01 << {~c1, e[7:6]} : 8'h00;
        i_host_master_model.start_cycle(a, ctl);
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("selected", sel, device_selected)
        `CHK("local", sel & loc, local_register_flag)
        `CHK("code", e[4:0], register_select_code)
        `CHK("in range", rng, register_in_range)
        `CHK("reply", sel & rng, reply_permitted)
        `CHK("drive request", sel & ~loc & rng, drive_request)
        `CHK("lower", lo, lower_decode)
        `CHK("upper", up, upper_decode)
        `CHK("direction", c1, drive_write_direction)
        `CHK("odd byte", sel & c1 & ctl[0] & a[0], odd_byte_write)
        for (int i = 1; i <= 11; i++)
        begin
            @(posedge clk_sys);
            #1;
            `CHK("strobe", (i == 9) & sel & loc & rng, local_register_strobe)
        end
        i_host_master_model.end_cycle();
        @(posedge clk_sys);
        #1;
        `CHK("released", 1'b0, device_selected | reply_permitted | drive_request)
        `CHK("lower idle", 8'h00, lower_decode | upper_decode)
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        logic [31:0] rd, tmp;
        logic [17:0] a;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        `CHK("reset selected", 1'b0, device_selected | wb_ack_o)
        wb_xfer(1'b0, 8'h00, 32'h00000000, rd);
        `CHK("cfg reset", 32'h00000000, rd)
        wb_xfer(1'b0, 8'h80, 32'h00000000, rd);
        `CHK("entry 0 remote", 3'b100, rd[7:5])
        wb_xfer(1'b0, 8'h40, 32'h00000000, rd);
        `CHK("unmapped", 32'h00000000, rd)
        for (int i = 0; i < 32; i++)
        begin
            tmp = rnd();
            tbl[i] = tmp[7:0];
            if (i == 0)
                tbl[i][5] = 1'b0;
            wb_xfer(1'b1, 8'h80 + 8'(4 * i), {24'h000000, tbl[i]}, rd);
        end
        wb_xfer(1'b0, 8'h9C, 32'h00000000, rd);
        `CHK("table readback", tbl[7], rd[7:0])
        for (int pass = 0; pass < 2; pass++)
        begin
            tmp = rnd();
            base = tmp[7:0];
            count = (tmp[11:8] == 4'h0) ? 4'hC : tmp[11:8];
            wide = pass[0];
            wb_xfer(1'b1, 8'h00, {19'h00000, wide, count, base}, rd);
            wb_xfer(1'b0, 8'h00, 32'h00000000, rd);
            `CHK("cfg", {19'h00000, wide, count, base}, rd)
            wb_xfer(1'b0, 8'h04, 32'h00000000, rd);
            `CHK("status", {24'h000000, 1'b1, tbl[0][4:0], 2'b00}, rd)
            for (int k = 0; k < 20; k++)
            begin
                tmp = rnd();
                a = {5'h1F, base, tmp[4:0]};
                if (wide)
                    a[5] = tmp[12];
                if (k < 2 && wide)
                    a[5:2] = count - 4'h1 + 4'(k);
                else if (k < 2)
                    a[4:1] = count - 4'h1 + 4'(k);
                else if (tmp[8:6] == 3'h0)
                    a[13 + tmp[10:9]] = 1'b0;
                else if (tmp[8:6] == 3'h1)
                    a[5 + tmp[11:9]] = ~a[5 + tmp[11:9]];
                host_check(a, 2'(k));
            end
        end
        close_out();
    end
endmodule
